// File: inc/sad_pkg.sv
// Constants and types shared by the shift-accumulate datapath.
// Assumes one core clock, a Wishbone register slave and a sequencer on the same clock.
package sad_pkg;

  // Register byte offsets on the Wishbone slave.
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_SHIFT = 8'h04;
  localparam logic [7:0] REG_PRODUCT_HIGH = 8'h08;
  localparam logic [7:0] REG_PROG_COUNTER = 8'h0C;
  localparam logic [7:0] REG_ACC_PTR = 8'h10;
  localparam logic [7:0] REG_ACC_BASE = 8'h40;
  localparam logic [7:0] REG_PTR_BASE = 8'h80;

  // Status register bit positions.
  localparam int STAT_XM = 0;
  localparam int STAT_OF = 1;
  localparam int STAT_SF = 2;
  localparam int STAT_ZF = 3;
  localparam int STAT_CF = 4;
  localparam int STAT_TAG = 5;
  localparam int STAT_BUSY = 8;

  // Reset values and fixed steps.
  localparam logic [15:0] RESET_PC = 16'h0000;
  localparam logic [3:0] RESET_SV = 4'h0;
  localparam logic [3:0] ACC_OFFSET_MASK = 4'h8;
  localparam logic [15:0] BYTE_STEP = 16'h0002;
  localparam logic [15:0] PC_STEP_ONE = 16'h0001;
  localparam logic [15:0] PC_STEP_TWO = 16'h0002;
  localparam logic [4:0] PROD_REPEAT_EXTRA = 5'h02;

  // Operations, one-hot.
  typedef enum logic [3:0] {
    OP_ADD_WORD = 4'b0001,
    OP_ADD_STRING = 4'b0010,
    OP_STR_PROD = 4'b0100,
    OP_SUB_WORD = 4'b1000
  } sad_op_t;

  // Source addressing, one-hot.
  typedef enum logic [4:0] {
    SRC_ACC = 5'b00001,
    SRC_DIRECT = 5'b00010,
    SRC_RELATIVE = 5'b00100,
    SRC_IND_INC = 5'b01000,
    SRC_IND_INDEX = 5'b10000
  } sad_src_t;

  // Accumulator pointer modifier, one-hot.
  typedef enum logic [2:0] {
    MOD_NONE = 3'b001,
    MOD_INC = 3'b010,
    MOD_DEC = 3'b100
  } sad_mod_t;

  // Sequencer states, one-hot.
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_FETCH = 4'b0010,
    ST_EXEC = 4'b0100,
    ST_FINISH = 4'b1000
  } sad_state_e_t;

  // One decoded instruction from the sequencer.
  typedef struct packed {
    sad_op_t op;
    sad_src_t src_mode;
    sad_mod_t modifier;
    logic [1:0] acc_sel;
    logic dest_offset;
    logic src_offset;
    logic [2:0] ptr_sel;
    logic [2:0] idx_sel;
    logic [3:0] str_len;
    logic repeat_mode;
    logic [15:0] second_word;
  } sad_cmd_t;

  // Status flags as seen outside.
  typedef struct packed {
    logic xm;
    logic overflow_flag;
    logic sign_flag;
    logic zero_flag;
    logic carry_flag;
    logic tag;
  } sad_flags_t;

endpackage

// File: verilog/sad_datapath.sv
// Shift-left accumulate datapath with its accumulator file and Wishbone registers.
// Assumes the sequencer and data memory share REF_CLK; memory answers with MEM_ACK.
`timescale 1ns/1ps
module sad_datapath
  import sad_pkg::*;
(
  // Clock and reset.
  input wire logic REF_CLK,
  input wire logic RST,
  // Wishbone register slave.
  input wire logic WB_CYC,
  input wire logic WB_STB,
  input wire logic WB_WE,
  input wire logic [7:0] WB_ADR,
  input wire logic [3:0] WB_SEL,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK,
  // Instruction from the sequencer.
  input wire logic CMD_VALID,
  input wire sad_cmd_t CMD,
  output logic CMD_READY,
  output logic DONE,
  // Data memory read port.
  output logic MEM_REQ,
  output logic [15:0] MEM_ADDR,
  input wire logic MEM_ACK,
  input wire logic [15:0] MEM_DATA,
  input wire logic MEM_TAG,
  // Architectural state seen by the core.
  output logic [15:0] PROG_COUNTER,
  output logic [15:0] PRODUCT_HIGH,
  output sad_flags_t FLAGS
);

  typedef struct packed {
    sad_state_e_t state;
    sad_cmd_t cmd;
    logic [15:0][15:0] acc;
    logic [7:0][15:0] ptr;
    logic [3:0][3:0] ap;
    logic [3:0] sv;
    logic [15:0] ph;
    logic [15:0] pc;
    sad_flags_t flags;
    logic [4:0] word_cnt;
    logic [4:0] word_last;
    logic [15:0] carry_bits;
    logic arith_c;
    logic zero_acc;
    logic [3:0] base_src;
    logic [3:0] base_dst;
    logic [15:0] operand;
    logic mem_req;
    logic [15:0] mem_addr;
    logic done;
    logic wb_ack;
    logic [31:0] wb_dat;
  } sad_regs_t;

  sad_regs_t s;
  sad_regs_t next_s;

  // Byte-lane merge for a 16-bit register held in the low half of the bus word.
  function automatic logic [15:0] lane_write(input logic [15:0] old, input logic [31:0] data,
                                             input logic [3:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = data[7:0];
    end
    if (sel[1]) begin
      r[15:8] = data[15:8];
    end
    return r;
  endfunction

  logic is_mem;
  logic is_sub;
  logic is_string;
  logic top_word;
  logic [3:0] src_idx;
  logic [3:0] dst_idx;
  logic [15:0] src_word;
  logic [15:0] ext;
  logic [31:0] wide;
  logic [15:0] pl;
  logic [15:0] hi;
  logic [15:0] dst_word;
  logic [15:0] opnd;
  logic [16:0] sum;
  logic [3:0] ap_mod;
  logic [15:0] wb_read;

  // Word datapath: shift, merge carried bits, add or subtract.
  always_comb begin
    is_mem = (s.cmd.src_mode != SRC_ACC);
    is_sub = (s.cmd.op == OP_SUB_WORD);
    is_string = (s.cmd.op == OP_ADD_STRING) || (s.cmd.op == OP_STR_PROD);
    top_word = (s.word_cnt == s.word_last);
    src_idx = 4'(s.base_src + s.word_cnt[3:0]);
    dst_idx = 4'(s.base_dst + s.word_cnt[3:0]);
    src_word = is_mem ? s.operand : s.acc[src_idx];
    // Only the most significant word of a string is sign extended.
    ext = (top_word && s.flags.xm && src_word[15]) ? 16'hFFFF : 16'h0000;
    wide = {ext, src_word} << s.sv;
    // Bits pushed out of the previous word fill the zeroed low end.
    pl = wide[15:0] | s.carry_bits;
    hi = wide[31:16];
    dst_word = s.acc[dst_idx];
    // Subtraction is the add of the inverted low half with carry-in one, or with the previous carry under repeat.
    opnd = is_sub ? ~pl : pl;
    sum = {1'b0, dst_word} + {1'b0, opnd} + {16'h0000, s.arith_c};
  end

  // Wishbone read mux; unmapped offsets read as zero.
  always_comb begin
    wb_read = 16'h0000;
    if (WB_ADR[7:6] == REG_ACC_BASE[7:6]) begin
      wb_read = s.acc[WB_ADR[5:2]];
    end else if (WB_ADR[7:5] == REG_PTR_BASE[7:5]) begin
      wb_read = s.ptr[WB_ADR[4:2]];
    end else begin
      case (WB_ADR)
        REG_STATUS: begin
          wb_read[STAT_XM] = s.flags.xm;
          wb_read[STAT_OF] = s.flags.overflow_flag;
          wb_read[STAT_SF] = s.flags.sign_flag;
          wb_read[STAT_ZF] = s.flags.zero_flag;
          wb_read[STAT_CF] = s.flags.carry_flag;
          wb_read[STAT_TAG] = s.flags.tag;
          wb_read[STAT_BUSY] = (s.state != ST_IDLE);
        end
        REG_SHIFT: wb_read = {12'h000, s.sv};
        REG_PRODUCT_HIGH: wb_read = s.ph;
        REG_PROG_COUNTER: wb_read = s.pc;
        REG_ACC_PTR: wb_read = s.ap;
        default: wb_read = 16'h0000;
      endcase
    end
  end

  // Next-state logic for the bus slave and the instruction sequence.
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.wb_ack = 1'b0;
    ap_mod = s.ap[CMD.acc_sel];

    // Ack one cycle after the strobe and drop it the cycle after. Writes land only
    // while idle with no instruction offered, so software never races the datapath.
    if (WB_CYC && WB_STB && !s.wb_ack) begin
      next_s.wb_ack = 1'b1;
      next_s.wb_dat = {16'h0000, wb_read};
      if (WB_WE && s.state == ST_IDLE && !CMD_VALID) begin
        if (WB_ADR[7:6] == REG_ACC_BASE[7:6]) begin
          next_s.acc[WB_ADR[5:2]] = lane_write(s.acc[WB_ADR[5:2]], WB_DAT_I, WB_SEL);
        end else if (WB_ADR[7:5] == REG_PTR_BASE[7:5]) begin
          next_s.ptr[WB_ADR[4:2]] = lane_write(s.ptr[WB_ADR[4:2]], WB_DAT_I, WB_SEL);
        end else begin
          case (WB_ADR)
            REG_STATUS: begin
              if (WB_SEL[0]) begin
                next_s.flags.xm = WB_DAT_I[STAT_XM];
                next_s.flags.overflow_flag = WB_DAT_I[STAT_OF];
                next_s.flags.sign_flag = WB_DAT_I[STAT_SF];
                next_s.flags.zero_flag = WB_DAT_I[STAT_ZF];
                next_s.flags.carry_flag = WB_DAT_I[STAT_CF];
                next_s.flags.tag = WB_DAT_I[STAT_TAG];
              end
            end
            REG_SHIFT: begin
              if (WB_SEL[0]) begin
                next_s.sv = WB_DAT_I[3:0];
              end
            end
            REG_PROG_COUNTER: next_s.pc = lane_write(s.pc, WB_DAT_I, WB_SEL);
            REG_ACC_PTR: next_s.ap = lane_write(s.ap, WB_DAT_I, WB_SEL);
            default: next_s.wb_ack = 1'b1;
          endcase
        end
      end
    end

    case (s.state)
      ST_IDLE: begin
        if (CMD_VALID) begin
          next_s.cmd = CMD;
          // Pointer moves before the operand is chosen.
          if (CMD.op == OP_ADD_WORD || CMD.op == OP_SUB_WORD) begin
            if (CMD.modifier == MOD_INC) begin
              ap_mod = 4'(s.ap[CMD.acc_sel] + 4'h1);
            end else if (CMD.modifier == MOD_DEC) begin
              ap_mod = 4'(s.ap[CMD.acc_sel] - 4'h1);
            end
          end
          next_s.ap[CMD.acc_sel] = ap_mod;
          next_s.base_dst = ap_mod ^ (CMD.dest_offset ? ACC_OFFSET_MASK : 4'h0);
          next_s.base_src = ap_mod ^ (CMD.src_offset ? ACC_OFFSET_MASK : 4'h0);
          next_s.word_cnt = 5'h00;
          next_s.word_last = 5'h00;
          if (CMD.op == OP_ADD_STRING || CMD.op == OP_STR_PROD) begin
            next_s.word_last = {1'b0, CMD.str_len};
          end
          // Repeat form of string to product runs two extra words.
          if (CMD.op == OP_STR_PROD && CMD.repeat_mode) begin
            next_s.word_last = 5'({1'b0, CMD.str_len} + PROD_REPEAT_EXTRA);
          end
          // Under repeat the shifted-out bits and carry continue into this word.
          if (!CMD.repeat_mode) begin
            next_s.carry_bits = 16'h0000;
            next_s.arith_c = (CMD.op == OP_SUB_WORD);
          end
          next_s.zero_acc = 1'b1;
          // Second instruction word gives the direct address or long offset.
          case (CMD.src_mode)
            SRC_DIRECT: next_s.mem_addr = CMD.second_word;
            SRC_RELATIVE: next_s.mem_addr = 16'(s.ptr[CMD.ptr_sel] + CMD.second_word);
            default: next_s.mem_addr = s.ptr[CMD.ptr_sel];
          endcase
          next_s.mem_req = (CMD.src_mode != SRC_ACC);
          next_s.state = (CMD.src_mode != SRC_ACC) ? ST_FETCH : ST_EXEC;
        end
      end
      ST_FETCH: begin
        if (MEM_ACK) begin
          next_s.operand = MEM_DATA;
          next_s.flags.tag = MEM_TAG;
          next_s.mem_req = 1'b0;
          next_s.state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        next_s.carry_bits = hi;
        next_s.arith_c = sum[16];
        if (s.cmd.op != OP_STR_PROD) begin
          // Accumulate into the destination.
          next_s.acc[dst_idx] = sum[15:0];
          next_s.zero_acc = s.zero_acc && (sum[15:0] == 16'h0000);
        end else begin
          // Accumulators untouched; low half is dropped.
          next_s.zero_acc = s.zero_acc && (hi == 16'h0000);
        end
        if (top_word) begin
          next_s.ph = hi;
          // Sign follows the final word, as do overflow and carry for add and subtract, whose zero flag covers every word.
          if (s.cmd.op == OP_STR_PROD) begin
            next_s.flags.overflow_flag = 1'b0;
            next_s.flags.sign_flag = hi[15];
            next_s.flags.zero_flag = (hi == 16'h0000);
            next_s.flags.carry_flag = 1'b0;
          end else begin
            next_s.flags.overflow_flag = (dst_word[15] == opnd[15]) &&
                                         (sum[15] != dst_word[15]);
            next_s.flags.sign_flag = sum[15];
            next_s.flags.zero_flag = s.zero_acc && (sum[15:0] == 16'h0000);
            next_s.flags.carry_flag = sum[16];
          end
          next_s.state = ST_FINISH;
        end else begin
          next_s.word_cnt = 5'(s.word_cnt + 5'h01);
          if (is_mem && is_string) begin
            next_s.mem_addr = 16'(s.mem_addr + BYTE_STEP);
            next_s.mem_req = 1'b1;
            next_s.state = ST_FETCH;
          end
        end
      end
      ST_FINISH: begin
        // Memory forms span two instruction words.
        next_s.pc = 16'(s.pc + (is_mem ? PC_STEP_TWO : PC_STEP_ONE));
        if (s.cmd.src_mode == SRC_IND_INC) begin
          next_s.ptr[s.cmd.ptr_sel] = 16'(s.ptr[s.cmd.ptr_sel] + BYTE_STEP);
        end else if (s.cmd.src_mode == SRC_IND_INDEX) begin
          next_s.ptr[s.cmd.ptr_sel] = 16'(s.ptr[s.cmd.ptr_sel] + s.ptr[s.cmd.idx_sel]);
        end
        next_s.done = 1'b1;
        next_s.state = ST_IDLE;
      end
      default: next_s.state = ST_IDLE;
    endcase
  end

  // State register; reset loads constants only.
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      s <= '0;
      s.state <= ST_IDLE;
      s.pc <= RESET_PC;
      s.sv <= RESET_SV;
    end else begin
      s <= next_s;
    end
  end

  // Ready is combinational so the sequencer can issue back to back after DONE.
  assign CMD_READY = (s.state == ST_IDLE);
  assign DONE = s.done;
  assign MEM_REQ = s.mem_req;
  assign MEM_ADDR = s.mem_addr;
  assign WB_ACK = s.wb_ack;
  assign WB_DAT_O = s.wb_dat;
  assign PROG_COUNTER = s.pc;
  assign PRODUCT_HIGH = s.ph;
  assign FLAGS = s.flags;

endmodule

// File: sim/sad_datapath_asserts.sv
// Port-level checks for the shift-accumulate datapath.
// Assumes the bind at the foot attaches it to every datapath instance.
`timescale 1ns/1ps
module sad_datapath_asserts
  import sad_pkg::*;
(
  // Clock and reset.
  input wire logic REF_CLK,
  input wire logic RST,
  // Register bus.
  input wire logic WB_CYC,
  input wire logic WB_STB,
  input wire logic WB_ACK,
  // Instruction port.
  input wire logic CMD_VALID,
  input wire sad_cmd_t CMD,
  input wire logic CMD_READY,
  input wire logic DONE,
  // Memory port.
  input wire logic MEM_REQ,
  input wire logic [15:0] MEM_ADDR,
  input wire logic MEM_ACK,
  input wire logic MEM_TAG,
  // Architectural state.
  input wire logic [15:0] PROG_COUNTER,
  input wire logic [15:0] PRODUCT_HIGH,
  input wire sad_flags_t FLAGS
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  logic mem_form;
  // Remember the addressing of the instruction in flight, since the step size hangs on it.
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      mem_form <= 1'b0;
    end else if (CMD_VALID && CMD_READY) begin
      mem_form <= (CMD.src_mode != SRC_ACC);
    end
  end
  ack_answer_a: assert property (WB_CYC && WB_STB && !WB_ACK |=> WB_ACK)
    else $error("bus access not answered next cycle");
  ack_pulse_a: assert property (WB_ACK |=> !WB_ACK)
    else $error("bus answer longer than one cycle");
  busy_after_take_a: assert property (CMD_VALID && CMD_READY |=> !CMD_READY)
    else $error("ready stayed high after a take");
  word_latency_a: assert property (CMD_VALID && CMD_READY && CMD.src_mode == SRC_ACC
    && CMD.op == OP_SUB_WORD |-> !DONE ##1 !DONE ##1 !DONE ##1 DONE)
    else $error("word subtract did not retire on the third edge");
  pc_step_a: assert property (DONE |-> PROG_COUNTER ==
    $past(PROG_COUNTER) + (mem_form ? PC_STEP_TWO : PC_STEP_ONE))
    else $error("program counter step wrong");
  mem_hold_a: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR))
    else $error("memory request dropped or moved before answer");
  mem_even_a: assert property (MEM_REQ |-> !MEM_ADDR[0])
    else $error("odd byte address on memory port");
  tag_follow_a: assert property (MEM_REQ && MEM_ACK |=> FLAGS.tag == $past(MEM_TAG))
    else $error("tag flag did not follow fetched word");
  ph_busy_a: assert property ($changed(PRODUCT_HIGH) |-> !$past(CMD_READY))
    else $error("product high moved while idle");
  cover property (DONE && mem_form);
  cover property (MEM_REQ && MEM_ACK && MEM_TAG);
  cover property (CMD_VALID && CMD_READY && CMD.op == OP_STR_PROD);
endmodule

bind sad_datapath sad_datapath_asserts chk (.REF_CLK(REF_CLK), .RST(RST), .WB_CYC(WB_CYC),
  .WB_STB(WB_STB), .WB_ACK(WB_ACK), .CMD_VALID(CMD_VALID), .CMD(CMD),
  .CMD_READY(CMD_READY), .DONE(DONE), .MEM_REQ(MEM_REQ), .MEM_ADDR(MEM_ADDR),
  .MEM_ACK(MEM_ACK), .MEM_TAG(MEM_TAG), .PROG_COUNTER(PROG_COUNTER),
  .PRODUCT_HIGH(PRODUCT_HIGH), .FLAGS(FLAGS));

// File: sim/sad_mem_model.sv
// Data memory stand-in for the datapath's read port; a word is its address byte-swapped.
// Assumes one read outstanding and the same clock as the datapath.
`timescale 1ns/1ps
module sad_mem_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Read port.
  input wire logic req,
  input wire logic [15:0] addr,
  input wire logic slow,
  output logic ack,
  output logic [15:0] data,
  output logic tag
);
  logic [1:0] wait_cnt;
  // Outside an answer the lines toggle, so a late sample never sees a stale good word.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack <= 1'b0;
      data <= 16'h0000;
      tag <= 1'b0;
      wait_cnt <= 2'h0;
    end else if (ack) begin
      ack <= 1'b0;
      data <= ~data;
      tag <= ~tag;
      wait_cnt <= 2'h0;
    end else if (req && (!slow || wait_cnt == 2'h3)) begin
      ack <= 1'b1;
      data <= {addr[7:0], addr[15:8]};
      tag <= addr[1];
    end else begin
      data <= ~data;
      tag <= ~tag;
      wait_cnt <= req ? wait_cnt + 2'h1 : 2'h0;
    end
  end
endmodule

// File: sim/sad_datapath_tb.sv
// Self-checking bench for the shift-accumulate datapath.
// Assumes the memory model on the read port and the bound checker.
`timescale 1ns/1ps
module sad_datapath_tb;
  import sad_pkg::*;
  logic clk, rst, cyc, stb, we, wack, cmd_valid, cmd_ready, done;
  logic mem_req, mem_ack, mem_tag, slow;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  logic [15:0] mem_addr, mem_data, pc, ph;
  sad_cmd_t cmd;
  sad_flags_t flags;
  int mismatches, n_tests;

  sad_datapath dut (.REF_CLK(clk), .RST(rst), .WB_CYC(cyc), .WB_STB(stb), .WB_WE(we),
    .WB_ADR(adr), .WB_SEL(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK(wack),
    .CMD_VALID(cmd_valid), .CMD(cmd), .CMD_READY(cmd_ready), .DONE(done),
    .MEM_REQ(mem_req), .MEM_ADDR(mem_addr), .MEM_ACK(mem_ack), .MEM_DATA(mem_data),
    .MEM_TAG(mem_tag), .PROG_COUNTER(pc), .PRODUCT_HIGH(ph), .FLAGS(flags));
  sad_mem_model mem (.clk(clk), .rst(rst), .req(mem_req), .addr(mem_addr), .slow(slow),
    .ack(mem_ack), .data(mem_data), .tag(mem_tag));

  // Core clock at 200 MHz.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One classic bus cycle, entered and left just after a rising edge.
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d,
                    output logic [15:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'b0011;
    wdat <= {16'h0000, d};
    do begin
      @(posedge clk);
      n++;
    end while (wack !== 1'b1 && n < 50);
    q = rdat[15:0];
    chk({15'h0000, wack}, 16'h0001, "bus answer");
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask

  // Offer one instruction and wait until it retires.
  task automatic run(input sad_cmd_t c);
    int n;
    n = 0;
    cmd_valid <= 1'b1;
    cmd <= c;
    @(posedge clk);
    cmd_valid <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (done !== 1'b1 && n < 50);
    chk({15'h0000, done}, 16'h0001, "instruction retired");
  endtask

  function automatic sad_cmd_t mk(input sad_op_t op, input sad_src_t src, input sad_mod_t m,
                                  input logic ofs, input logic [3:0] len, input logic [15:0] w2);
    sad_cmd_t c;
    c = '0;
    c.op = op;
    c.src_mode = src;
    c.modifier = m;
    c.dest_offset = ofs;
    c.src_offset = ofs;
    c.ptr_sel = 3'h2;
    c.str_len = len;
    c.second_word = w2;
    return c;
  endfunction

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Reset program counter, then a word subtract whose result borrows.
  task automatic t_sub();
    logic [15:0] q;
    wb(1'b0, REG_PROG_COUNTER, 16'h0000, q);
    chk(q, RESET_PC, "pc after reset");
    wb(1'b1, 8'h20, 16'hBEEF, q);
    wb(1'b0, 8'h20, 16'h0000, q);
    chk(q, 16'h0000, "unmapped read");
    wb(1'b1, REG_SHIFT, 16'h0004, q);
    wb(1'b1, REG_ACC_BASE, 16'h1234, q);
    run(mk(OP_SUB_WORD, SRC_ACC, MOD_NONE, 1'b0, 4'h0, 16'h0000));
    chk(ph, 16'h0001, "subtract high half");
    chk({12'h000, flags.overflow_flag, flags.sign_flag, flags.zero_flag,
         flags.carry_flag}, 16'h0004, "subtract flags");
    wb(1'b0, REG_ACC_BASE, 16'h0000, q);
    chk(q, 16'hEEF4, "subtract result");
    chk(pc, 16'h0001, "pc one word");
    $display("test subtract done");
  endtask

  // Memory forms: a slow direct read, then a prompt indirect read with post-increment.
  task automatic t_mem();
    logic [15:0] q;
    slow <= 1'b1;
    run(mk(OP_ADD_WORD, SRC_DIRECT, MOD_NONE, 1'b1, 4'h0, 16'h0012));
    chk(ph, 16'h0001, "direct high half");
    chk({15'h0000, flags.tag}, 16'h0001, "direct tag");
    wb(1'b0, 8'h60, 16'h0000, q);
    chk(q, 16'h2000, "direct sum");
    chk(pc, 16'h0003, "pc two words");
    slow <= 1'b0;
    wb(1'b1, 8'h88, 16'h0020, q);
    run(mk(OP_ADD_WORD, SRC_IND_INC, MOD_NONE, 1'b1, 4'h0, 16'h0000));
    chk(ph, 16'h0002, "indirect high half");
    chk({15'h0000, flags.tag}, 16'h0000, "indirect tag");
    wb(1'b0, 8'h88, 16'h0000, q);
    chk(q, 16'h0022, "pointer advanced");
    chk(pc, 16'h0005, "pc two words");
    $display("test memory done");
  endtask

  // String to product keeps the string; a modified word subtract sign-extends.
  task automatic t_prod();
    logic [15:0] q;
    run(mk(OP_STR_PROD, SRC_ACC, MOD_NONE, 1'b0, 4'h1, 16'h0000));
    // Nothing leaves the top of {0x0000, 0xEEF4} when shifted by four.
    chk(ph, 16'h0000, "string product high half");
    wb(1'b0, REG_ACC_BASE, 16'h0000, q);
    chk(q, 16'hEEF4, "string word 0 kept");
    wb(1'b0, 8'h44, 16'h0000, q);
    chk(q, 16'h0000, "string word 1 kept");
    chk(pc, 16'h0006, "pc one word");
    wb(1'b1, REG_STATUS, 16'h0001, q);
    wb(1'b1, 8'h44, 16'h8000, q);
    run(mk(OP_SUB_WORD, SRC_ACC, MOD_INC, 1'b0, 4'h0, 16'h0000));
    chk(ph, 16'hFFF8, "sign-extended high half");
    wb(1'b0, REG_ACC_PTR, 16'h0000, q);
    chk(q, 16'h0001, "pointer premodified");
    wb(1'b0, 8'h44, 16'h0000, q);
    chk(q, 16'h8000, "modified operand result");
    $display("test product done");
  endtask

  // Strings, repeat chaining and the remaining memory addressing forms.
  task automatic t_string();
    logic [15:0] q;
    sad_cmd_t c;
    wb(1'b1, REG_STATUS, 16'h0000, q);
    wb(1'b1, REG_ACC_PTR, 16'h0000, q);
    wb(1'b1, REG_ACC_BASE, 16'hFFF1, q);
    wb(1'b1, 8'h44, 16'h1234, q);
    wb(1'b1, 8'h48, 16'hABCD, q);
    wb(1'b1, 8'h8C, 16'h0010, q);
    // Two words act as one: 0x1234_FFF1 plus itself shifted left by four.
    run(mk(OP_ADD_STRING, SRC_ACC, MOD_NONE, 1'b0, 4'h1, 16'h0000));
    chk(ph, 16'h0001, "string add high half");
    wb(1'b0, REG_ACC_BASE, 16'h0000, q);
    chk(q, 16'hFF01, "string add low word");
    wb(1'b0, 8'h44, 16'h0000, q);
    chk(q, 16'h3584, "string add carried word");
    // Under repeat a one-word string runs three words, so the top word is the third.
    c = mk(OP_STR_PROD, SRC_ACC, MOD_NONE, 1'b0, 4'h0, 16'h0000);
    c.repeat_mode = 1'b1;
    run(c);
    chk(ph, 16'h000A, "repeat product high half");
    wb(1'b0, 8'h48, 16'h0000, q);
    chk(q, 16'hABCD, "repeat string kept");
    // A plain subtract, then a chained one on the next accumulator: one wide subtract.
    run(mk(OP_SUB_WORD, SRC_ACC, MOD_NONE, 1'b0, 4'h0, 16'h0000));
    c = mk(OP_SUB_WORD, SRC_ACC, MOD_INC, 1'b0, 4'h0, 16'h0000);
    c.repeat_mode = 1'b1;
    run(c);
    chk(ph, 16'h0003, "chained subtract high half");
    chk({12'h000, flags.overflow_flag, flags.sign_flag, flags.zero_flag,
         flags.carry_flag}, 16'h0004, "chained subtract flags");
    wb(1'b0, REG_ACC_BASE, 16'h0000, q);
    chk(q, 16'h0EF1, "chained subtract low word");
    wb(1'b0, 8'h44, 16'h0000, q);
    chk(q, 16'hDD35, "chained subtract high word");
    // Indexed post-modify, then a long relative offset from the moved pointer.
    c = mk(OP_ADD_WORD, SRC_IND_INDEX, MOD_NONE, 1'b1, 4'h0, 16'h0000);
    c.idx_sel = 3'h3;
    run(c);
    chk(ph, 16'h0002, "indexed high half");
    chk({15'h0000, flags.tag}, 16'h0001, "indexed tag");
    wb(1'b0, 8'h88, 16'h0000, q);
    chk(q, 16'h0032, "pointer plus index");
    run(mk(OP_ADD_WORD, SRC_RELATIVE, MOD_NONE, 1'b1, 4'h0, 16'h0102));
    chk(ph, 16'h0003, "relative high half");
    chk({15'h0000, flags.tag}, 16'h0000, "relative tag");
    wb(1'b0, 8'h64, 16'h0000, q);
    chk(q, 16'h6010, "relative sum");
    chk(pc, 16'h000F, "pc after mixed forms");
    $display("test string done");
  endtask

  // Main sequence.
  initial begin
    rst = 1'b1;
    {cyc, stb, we, cmd_valid, slow} = 5'h00;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0000_0000;
    cmd = '0;
    mismatches = 0;
    n_tests = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_sub();
    t_mem();
    t_prod();
    t_string();
    complete_run();
  end

  // Watchdog: the run needs under two hundred cycles, so 10000 means a hang.
  initial begin
    #50000;
    mismatches++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule
